// ==== hdl/rotate_left_unit.sv ====
// rotate-left datapath with axi4-lite register access
// assumes register file answers rf_rdata combinationally while rf_rd_en is high
//
// Overview of operation
// - through-carry rotate: bit7 into carry, old carry into bit0; update C,N,Z
// - no-carry rotate: bit7 into bit0; update N,Z only, carry kept
// - destination bit 0 writes accumulator, 1 writes back source register
// - bank bit 0 uses fixed access bank, 1 uses bank select register
// - 16-bit word: opcode, destination bit, bank bit, 8-bit register address
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
module rotate_left_unit (
    // clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // core decoder
    input  wire rotate_left_pkg::instr_t instr,
    output logic                         instr_ready,
    // data register file
    output rotate_left_pkg::rf_req_t     rf_req,
    input  wire logic [7:0]              rf_rdata,
    // axi4-lite write
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    output logic [1:0]                   s_axi_bresp,
    // axi4-lite read
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    input  wire logic [7:0]              s_axi_araddr,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    // core state
    output logic [7:0]                   acc_out,
    output logic [2:0]                   flags_out
);

    rotate_left_pkg::state_t s_q;
    rotate_left_pkg::state_t s_d;

    logic [5:0] opcode;
    logic       hit_carry;
    logic       hit_nocarry;
    logic [7:0] faddr;
    logic [7:0] rot;
    logic       wr_go;
    logic       mapped_w;
    logic       mapped_r;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    assign opcode      = instr.word[rotate_left_pkg::OPC_HI:rotate_left_pkg::OPC_LO];
    assign hit_carry   = opcode == rotate_left_pkg::OPC_ROT_CARRY;
    assign hit_nocarry = opcode == rotate_left_pkg::OPC_ROT_NOCARRY;
    assign faddr       = instr.word[7:0];
    assign instr_ready = s_q.phase == rotate_left_pkg::PH_DECODE;

    // rotate by one, bit0 from carry or bit7
    assign rot = {s_q.operand[6:0], s_q.carry_op ? s_q.c : s_q.operand[7]};

    assign wr_go    = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign mapped_w = s_q.awaddr == rotate_left_pkg::OFF_BANK || s_q.awaddr == rotate_left_pkg::OFF_ACC
                   || s_q.awaddr == rotate_left_pkg::OFF_FLAGS;
    assign mapped_r = s_axi_araddr == rotate_left_pkg::OFF_BANK || s_axi_araddr == rotate_left_pkg::OFF_ACC
                   || s_axi_araddr == rotate_left_pkg::OFF_FLAGS || s_axi_araddr == rotate_left_pkg::OFF_COUNT;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d          = s_q;
        s_d.rf.rd_en = 1'b0;
        s_d.rf.wr_en = 1'b0;

        // four-phase sequence, free running
        unique case (s_q.phase)
            rotate_left_pkg::PH_DECODE: begin
                s_d.phase = rotate_left_pkg::PH_READ;
                s_d.busy  = instr.valid && (hit_carry || hit_nocarry);
                if (instr.valid && (hit_carry || hit_nocarry)) begin
                    s_d.carry_op = hit_carry;
                    s_d.dest_acc = instr.word[rotate_left_pkg::DEST_BIT] == rotate_left_pkg::DEST_ACC;
                    s_d.rf.rd_en = 1'b1;
                    if (instr.word[rotate_left_pkg::BANK_BIT] == rotate_left_pkg::BANK_FIXED) begin
                        s_d.rf.addr = {(faddr < rotate_left_pkg::ACCESS_SPLIT) ? rotate_left_pkg::ACCESS_LO_BANK
                                                                               : rotate_left_pkg::ACCESS_HI_BANK,
                                       faddr};
                    end else begin
                        s_d.rf.addr = {s_q.bank, faddr};
                    end
                end
            end
            rotate_left_pkg::PH_READ: begin
                s_d.phase = rotate_left_pkg::PH_PROCESS;
                if (s_q.busy) begin
                    s_d.operand = rf_rdata;
                end
            end
            rotate_left_pkg::PH_PROCESS: begin
                s_d.phase = rotate_left_pkg::PH_WRITE;
                if (s_q.busy) begin
                    s_d.result   = rot;
                    s_d.rf.wdata = rot;
                    s_d.rf.wr_en = !s_q.dest_acc;
                end
            end
            rotate_left_pkg::PH_WRITE: begin
                s_d.phase = rotate_left_pkg::PH_DECODE;
            end
        endcase

        // software writes
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_held = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end
        if (wr_go) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = mapped_w ? rotate_left_pkg::RESP_OKAY : rotate_left_pkg::RESP_SLVERR;
            if (s_q.wstrb[0]) begin
                unique case (s_q.awaddr)
                    rotate_left_pkg::OFF_BANK:  s_d.bank = s_q.wdata[3:0];
                    rotate_left_pkg::OFF_ACC:   s_d.acc  = s_q.wdata[7:0];
                    rotate_left_pkg::OFF_FLAGS: begin
                        s_d.c = s_q.wdata[rotate_left_pkg::FLAG_C];
                        s_d.z = s_q.wdata[rotate_left_pkg::FLAG_Z];
                        s_d.n = s_q.wdata[rotate_left_pkg::FLAG_N];
                    end
                    default: ;
                endcase
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // instruction completion wins over a software write in the same cycle
        if (s_q.phase == rotate_left_pkg::PH_WRITE && s_q.busy) begin
            if (s_q.dest_acc) begin
                s_d.acc = s_q.result;
            end
            s_d.n = s_q.result[7];
            s_d.z = s_q.result == 8'h00;
            if (s_q.carry_op) begin
                s_d.c = s_q.operand[7];
            end
            s_d.count = s_q.count + 32'h1;
            s_d.busy  = 1'b0;
        end

        // software reads
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = mapped_r ? rotate_left_pkg::RESP_OKAY : rotate_left_pkg::RESP_SLVERR;
            s_d.rdata  = 32'h0;
            unique case (s_axi_araddr)
                rotate_left_pkg::OFF_BANK:  s_d.rdata[3:0] = s_q.bank;
                rotate_left_pkg::OFF_ACC:   s_d.rdata[7:0] = s_q.acc;
                rotate_left_pkg::OFF_FLAGS: begin
                    s_d.rdata[rotate_left_pkg::FLAG_C] = s_q.c;
                    s_d.rdata[rotate_left_pkg::FLAG_Z] = s_q.z;
                    s_d.rdata[rotate_left_pkg::FLAG_N] = s_q.n;
                end
                rotate_left_pkg::OFF_COUNT: s_d.rdata = s_q.count;
                default: ;
            endcase
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q       <= '0;
            s_q.phase <= rotate_left_pkg::PH_DECODE;
            s_q.bank  <= rotate_left_pkg::BANK_RESET;
            s_q.acc   <= rotate_left_pkg::ACC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rf_req        = s_q.rf;
    assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_held && !s_q.bvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign acc_out       = s_q.acc;
    assign flags_out     = {s_q.n, s_q.z, s_q.c};

endmodule : rotate_left_unit

// ==== hdl/rotate_left_pkg.sv ====
// package for the rotate-left unit: encodings, register map, state types
// assumes an axi4-lite master and a core decoder on the same aclk
package rotate_left_pkg;

    // instruction word fields
    localparam logic [5:0]  OPC_ROT_CARRY   = 6'h0d;   // 0011 01
    localparam logic [5:0]  OPC_ROT_NOCARRY = 6'h11;   // 0100 01
    localparam int          OPC_HI          = 15;
    localparam int          OPC_LO          = 10;
    localparam int          DEST_BIT        = 9;
    localparam int          BANK_BIT        = 8;
    localparam logic        DEST_ACC        = 1'h0;
    localparam logic        BANK_FIXED      = 1'h0;

    // fixed access bank split
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
    localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;

    // register map
    localparam logic [7:0]  OFF_BANK        = 8'h00;
    localparam logic [7:0]  OFF_ACC         = 8'h04;
    localparam logic [7:0]  OFF_FLAGS       = 8'h08;
    localparam logic [7:0]  OFF_COUNT       = 8'h0c;
    localparam int          FLAG_C          = 0;
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_N          = 4;
    localparam logic [3:0]  BANK_RESET      = 4'h0;
    localparam logic [7:0]  ACC_RESET       = 8'h00;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE   = 2'b11
    } phase_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } instr_t;

    typedef struct packed {
        logic        rd_en;
        logic        wr_en;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } rf_req_t;

    typedef struct packed {
        phase_t      phase;
        logic        busy;
        logic        carry_op;
        logic        dest_acc;
        logic [7:0]  operand;
        logic [7:0]  result;
        rf_req_t     rf;
        logic [7:0]  acc;
        logic        c;
        logic        z;
        logic        n;
        logic [3:0]  bank;
        logic [31:0] count;
        logic        aw_held;
        logic        w_held;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;

endpackage : rotate_left_pkg

// ==== sim/rotate_left_monitor.sv ====
// checker on the rotate-left unit ports
// assumes bind into rotate_left_unit, one clock
module rotate_left_monitor (
    // watched ports
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire rotate_left_pkg::instr_t  instr,
    input wire logic                     instr_ready,
    input wire rotate_left_pkg::rf_req_t rf_req,
    input wire logic [7:0]               rf_rdata,
    input wire logic [2:0]               flags_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cy, nc, tk;
    logic [7:0] op_q;
    // operand seen by the unit in its read phase
    always_ff @(posedge aclk) begin
        if (rf_req.rd_en) begin
            op_q <= rf_rdata;
        end
    end
    assign cy = instr.word[15:10] == rotate_left_pkg::OPC_ROT_CARRY;
    assign nc = instr.word[15:10] == rotate_left_pkg::OPC_ROT_NOCARRY;
    assign tk = instr.valid && instr_ready && (cy || nc);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    property p_rd; tk |=> rf_req.rd_en && rf_req.addr[7:0] == $past(instr.word[7:0]); endproperty
    a_rd: assert property (p_rd) else $error("read request wrong");
    property p_bank; tk && !instr.word[8] |=> rf_req.addr[11:8] == (rf_req.addr[7] ? 4'hf : 4'h0); endproperty
    a_bank: assert property (p_bank) else $error("access bank wrong");
    property p_rdy; tk |=> !instr_ready [*3] ##1 instr_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("phase count wrong");
    property p_wr; tk |-> ##3 rf_req.wr_en == $past(instr.word[9], 3); endproperty
    a_wr: assert property (p_wr) else $error("write steer wrong");
    property p_nc; tk && nc && instr.word[9] |-> ##3 rf_req.wdata == {op_q[6:0], op_q[7]}; endproperty
    a_nc: assert property (p_nc) else $error("plain rotate wrong");
    property p_cy; tk && cy && instr.word[9] |->
        ##3 rf_req.wdata == {op_q[6:0], flags_out[0]} ##1 flags_out[0] == op_q[7]; endproperty
    a_cy: assert property (p_cy) else $error("carry rotate wrong");
    property p_keep; tk && nc |-> ##4 flags_out[0] == $past(flags_out[0], 4); endproperty
    a_keep: assert property (p_keep) else $error("carry changed");
    property p_nz; rf_req.wr_en |=> flags_out[2:1] == {rf_req.wdata[7], rf_req.wdata == 8'h00}; endproperty
    a_nz: assert property (p_nz) else $error("n or z wrong");
    c_cy: cover property (tk && cy);
    c_nc: cover property (tk && nc);
    c_fix: cover property (tk && !instr.word[8]);
endmodule : rotate_left_monitor
bind rotate_left_unit rotate_left_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .instr(instr),
    .instr_ready(instr_ready), .rf_req(rf_req), .rf_rdata(rf_rdata), .flags_out(flags_out));

// ==== sim/rf_model.sv ====
// register file model on the unit's far side
// assumes one aclk; data valid only while rd_en is high
module rf_model (
    // clock and request
    input  wire logic                     aclk,
    input  wire rotate_left_pkg::rf_req_t rf_req,
    output logic [7:0]                    rf_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    logic [7:0] last_q;
    initial begin
        last_q = 8'h00;
        for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ i[11:4];
    end
    ////////////////////////////////////////
    // idle bus shows inverse of last value
    assign rf_rdata = rf_req.rd_en ? mem[rf_req.addr] : ~last_q;
    always @(posedge aclk) begin
        if (rf_req.rd_en) last_q <= mem[rf_req.addr];
        if (rf_req.wr_en) mem[rf_req.addr] <= rf_req.wdata;
    end
endmodule : rf_model

// ==== sim/testbench.sv ====
// self-checking bench for the rotate-left unit
// assumes rf_model as register file, checker bound in its own file
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     aclk, aresetn, instr_ready, s_axi_awvalid, s_axi_awready, s_axi_wvalid, c, cy;
    logic                     s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                     s_axi_rvalid, s_axi_rready;
    logic [7:0]               s_axi_awaddr, s_axi_araddr, acc_out, rf_rdata, acc, v, r, mm [4096];
    logic [31:0]              s_axi_wdata, s_axi_rdata, w;
    logic [3:0]               s_axi_wstrb, bank;
    logic [1:0]               s_axi_bresp, s_axi_rresp;
    logic [2:0]               flags_out;
    logic [11:0]              ad;
    rotate_left_pkg::instr_t  instr;
    rotate_left_pkg::rf_req_t rf_req;
    int                       err_total, checks, seed, cnt, i;
    rotate_left_unit i_dut (.aclk(aclk), .aresetn(aresetn), .instr(instr), .instr_ready(instr_ready),
        .rf_req(rf_req), .rf_rdata(rf_rdata), .acc_out(acc_out), .flags_out(flags_out),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
    rf_model         i_rf (.aclk(aclk), .rf_req(rf_req), .rf_rdata(rf_rdata));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    task automatic fail();
        err_total++;
        final_report();
    endtask : fail
    task automatic ax(input bit wr, input logic [7:0] a, input logic [31:0] d, input bit bad);
        logic ao, wo;
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid  <= wr;
        s_axi_arvalid <= !wr;
        for (n = 0; n < 20; n++) begin
            @(negedge aclk);
            if ((wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1) break;
            ao = wr ? s_axi_awready : s_axi_arready;
            wo = s_axi_wready;
            @(posedge aclk);
            if (ao) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (wo) s_axi_wvalid <= 1'b0;
        end
        if (n == 20) fail();
        if (!wr) chk("rdata", s_axi_rdata, d);
        chk("resp", wr ? s_axi_bresp : s_axi_rresp, bad ? rotate_left_pkg::RESP_SLVERR : rotate_left_pkg::RESP_OKAY);
        @(posedge aclk);
    endtask : ax
    task automatic issue(input logic [15:0] wd);
        logic ok;
        int n;
        @(posedge aclk);
        instr <= {1'b1, wd};
        for (n = 0; n < 8; n++) begin
            @(negedge aclk);
            ok = instr_ready;
            @(posedge aclk);
            if (ok) break;
        end
        instr <= '0;
        if (n == 8) fail();
    endtask : issue
    ////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, c, acc, bank} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
        instr = '0;
        seed = 32'h5177d59f;
        for (i = 0; i < 4096; i++) mm[i] = i[7:0] ^ i[11:4];
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("acc reset", acc_out, 8'h00);
        chk("flags reset", flags_out, 3'h0);
        ax(0, rotate_left_pkg::OFF_BANK, 32'h0, 0);
        ax(1, rotate_left_pkg::OFF_ACC, 32'ha5, 0);
        acc = 8'ha5;
        ax(0, rotate_left_pkg::OFF_ACC, 32'ha5, 0);
        ax(1, 8'h10, 32'h0, 1);
        ax(0, 8'h10, 32'h0, 1);
        $display("register test done");
        for (i = 0; i < 40; i++) begin
            if (i[2:0] == 3'h0) begin
                w = $random(seed);
                ax(1, rotate_left_pkg::OFF_BANK, w, 0);
                bank = w[3:0];
            end
            w = $random(seed);
            cy = w[15];
            w[15:10] = cy ? rotate_left_pkg::OPC_ROT_CARRY : rotate_left_pkg::OPC_ROT_NOCARRY;
            w[9:8] = i[1:0];
            if (i < 4) w[7:0] = 8'h7f + i[7:0];
            ad = w[8] ? {bank, w[7:0]} : {w[7] ? 4'hf : 4'h0, w[7:0]};
            v = mm[ad];
            r = {v[6:0], cy ? c : v[7]};
            if (cy) c = v[7];
            if (w[9]) mm[ad] = r;
            else acc = r;
            cnt++;
            issue(w[15:0]);
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            chk("acc", acc_out, acc);
            chk("flags", flags_out, {r[7], r == 8'h00, c});
            chk("reg", i_rf.mem[ad], mm[ad]);
        end
        $display("rotate test done");
        issue(16'hffff);
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("acc ignored", acc_out, acc);
        ax(0, rotate_left_pkg::OFF_COUNT, cnt, 0);
        ax(0, rotate_left_pkg::OFF_FLAGS, {r[7], 1'b0, r == 8'h00, 1'b0, c}, 0);
        $display("summary test done");
        final_report();
    end
endmodule : testbench
